// [design/tlw_tap_timing.sv]
// tap quiet-time and second-tap window timing with its register file
`timescale 1ns/10ps
module tlw_tap_timing import tlw_pkg::*; #(
	parameter int BASE_CYCLES = TLW_BASE_STEP_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_en_in,
	input wire logic [7:0] reg_wr_data_in,
	input wire logic reg_rd_en_in,
	output logic [7:0] reg_rd_data_out,
	input wire logic [2:0] sample_rate_in,
	input wire logic [1:0] power_mode_in,
	input wire logic double_tap_mode_in,
	input wire logic pulse_start_in,
	input wire logic pulse_done_in,
	input wire logic pulse_valid_in,
	output logic single_tap_out,
	output logic double_tap_out,
	output logic pulse_ignored_out,
	output logic quiet_active_out,
	output logic window_active_out
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0] quiet_count;
	logic [7:0] window_count;
	logic tap_lowpass_enable;
	tlw_state_e state;
	tlw_state_e next_state;
	logic [7:0] time_left;
	logic [3:0] step_exp;
	logic step_tick;
	logic first_tap;
	logic enter_quiet;
	logic enter_window;
	logic restart;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	// software writes, registers at documented offsets
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			quiet_count <= TLW_RST_QUIET;
			window_count <= TLW_RST_WINDOW;
			tap_lowpass_enable <= TLW_RST_CFG[TLW_LPF_BIT];
		end else if (reg_wr_en_in) begin
			case (reg_addr_in)
				TLW_ADDR_QUIET: quiet_count <= reg_wr_data_in;
				TLW_ADDR_WINDOW: window_count <= reg_wr_data_in;
				TLW_ADDR_CFG: tap_lowpass_enable <= reg_wr_data_in[TLW_LPF_BIT];
				default: ;
			endcase
		end
	end

	// registered read data, unmapped offsets read zero
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reg_rd_data_out <= 8'h00;
		end else if (reg_rd_en_in) begin
			case (reg_addr_in)
				TLW_ADDR_QUIET: reg_rd_data_out <= quiet_count;
				TLW_ADDR_WINDOW: reg_rd_data_out <= window_count;
				TLW_ADDR_CFG: reg_rd_data_out <= 8'(tap_lowpass_enable) << TLW_LPF_BIT;
				default: reg_rd_data_out <= TLW_RD_UNMAPPED;
			endcase
		end
	end

	// ------------------------------------------------------------
	// step selection and tick
	// ------------------------------------------------------------
	// one schedule serves both timers
	assign step_exp = tlw_step_exp(sample_rate_in, power_mode_in, tap_lowpass_enable);
	assign restart = enter_quiet || enter_window;

	tlw_step_tick #(
		.BASE_CYCLES(BASE_CYCLES)
	) u_tick (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.step_exp_in(step_exp),
		.restart_in(restart),
		.step_tick_out(step_tick)
	);

	// ------------------------------------------------------------
	// tap sequencing
	// ------------------------------------------------------------
	// a tap is only qualified once the pulse ended inside the time limit
	assign first_tap = (state == TLW_IDLE) && pulse_done_in && pulse_valid_in;
	assign enter_quiet = first_tap;
	assign enter_window = (state == TLW_QUIET) && (time_left == 8'h00) && double_tap_mode_in;

	// next state
	always_comb begin
		next_state = state;
		case (state)
			TLW_IDLE: begin
				if (first_tap) begin
					next_state = TLW_QUIET;
				end
			end
			TLW_QUIET: begin
				// pulses are not looked at here at all
				if (time_left == 8'h00) begin
					next_state = double_tap_mode_in ? TLW_WINDOW : TLW_IDLE;
				end
			end
			TLW_WINDOW: begin
				// a start on the closing cycle still counts as inside
				if (pulse_start_in) begin
					next_state = TLW_SECOND;
				end else if (time_left == 8'h00) begin
					next_state = TLW_IDLE;
				end
			end
			TLW_SECOND: begin
				if (pulse_done_in) begin
					next_state = TLW_IDLE;
				end
			end
			default: next_state = TLW_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= TLW_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// shared down-counter for quiet time and window
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			time_left <= 8'h00;
		end else if (enter_quiet) begin
			time_left <= quiet_count;
		end else if (enter_window) begin
			time_left <= window_count;
		end else if (step_tick && (time_left != 8'h00) &&
			((state == TLW_QUIET) || (state == TLW_WINDOW))) begin
			time_left <= time_left - 8'h01;
		end
	end

	// event and status outputs
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			single_tap_out <= 1'b0;
			double_tap_out <= 1'b0;
			pulse_ignored_out <= 1'b0;
			quiet_active_out <= 1'b0;
			window_active_out <= 1'b0;
		end else begin
			single_tap_out <= first_tap;
			double_tap_out <= (state == TLW_SECOND) && pulse_done_in && pulse_valid_in;
			pulse_ignored_out <= (state == TLW_QUIET) && (pulse_start_in || pulse_done_in);
			quiet_active_out <= (next_state == TLW_QUIET);
			window_active_out <= (next_state == TLW_WINDOW);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_first_tap;
		(state == TLW_IDLE) && pulse_done_in && pulse_valid_in;
	endsequence

	sequence s_quiet_over;
		(state == TLW_QUIET) && (time_left == 8'h00);
	endsequence

	sequence s_second_start;
		(state == TLW_WINDOW) && pulse_start_in;
	endsequence

	chk_quiet_reg_write: assert property (
		reg_wr_en_in && (reg_addr_in == TLW_ADDR_QUIET) |=> quiet_count == $past(reg_wr_data_in))
		else $error("quiet count not written");

	chk_window_reg_write: assert property (
		reg_wr_en_in && (reg_addr_in == TLW_ADDR_WINDOW) |=> window_count == $past(reg_wr_data_in))
		else $error("window count not written");

	chk_first_tap_quiet: assert property (
		s_first_tap |=> (state == TLW_QUIET) && (time_left == $past(quiet_count)) && single_tap_out)
		else $error("first tap did not start quiet time");

	chk_quiet_ignores: assert property (
		(state == TLW_QUIET) && pulse_start_in |=> pulse_ignored_out && !double_tap_out)
		else $error("pulse not ignored during quiet time");

	chk_quiet_step_count: assert property (
		(state == TLW_QUIET) && step_tick && (time_left != 8'h00)
		|=> time_left == $past(time_left) - 8'h01)
		else $error("quiet counter did not step");

	chk_step_cap: assert property (
		tap_lowpass_enable && (power_mode_in == TLW_PM_HIRES) |-> step_exp <= 4'h2)
		else $error("filtered high resolution step above cap");

	chk_step_nolpf: assert property (
		!tap_lowpass_enable && (sample_rate_in <= 3'h1) && (power_mode_in != TLW_PM_LP)
		|-> step_exp == 4'h0)
		else $error("unfiltered fast step not base step");

	chk_window_opens: assert property (
		s_quiet_over ##0 double_tap_mode_in
		|=> (state == TLW_WINDOW) && (time_left == $past(window_count)) && window_active_out)
		else $error("window did not open after quiet time");

	chk_single_closes: assert property (
		s_quiet_over ##0 !double_tap_mode_in |=> state == TLW_IDLE)
		else $error("quiet time did not end");

	chk_second_invalid: assert property (
		(state == TLW_SECOND) && pulse_done_in && !pulse_valid_in
		|=> !double_tap_out && (state == TLW_IDLE))
		else $error("over-long second tap accepted");

	chk_second_late_end: assert property (
		s_second_start |=> state == TLW_SECOND)
		else $error("second tap lost after window start");

	chk_second_holds: assert property (
		(state == TLW_SECOND) && !pulse_done_in |=> state == TLW_SECOND)
		else $error("second tap dropped before it ended");

	chk_window_expiry: assert property (
		(state == TLW_WINDOW) && (time_left == 8'h00) && !pulse_start_in |=> state == TLW_IDLE)
		else $error("window did not close at zero");

	chk_cfg_reg_write: assert property (
		reg_wr_en_in && (reg_addr_in == TLW_ADDR_CFG) |=> tap_lowpass_enable == $past(reg_wr_data_in[TLW_LPF_BIT]))
		else $error("filter enable not written");

	chk_quiet_reg_read: assert property (
		reg_rd_en_in && (reg_addr_in == TLW_ADDR_QUIET) |=> reg_rd_data_out == $past(quiet_count))
		else $error("quiet count read wrong");

	chk_window_reg_read: assert property (
		reg_rd_en_in && (reg_addr_in == TLW_ADDR_WINDOW) |=> reg_rd_data_out == $past(window_count))
		else $error("window count read wrong");

	chk_cfg_reg_read: assert property (
		reg_rd_en_in && (reg_addr_in == TLW_ADDR_CFG) |=> (reg_rd_data_out[TLW_LPF_BIT] ==
		$past(tap_lowpass_enable)) && ((reg_rd_data_out & ~(8'h01 << TLW_LPF_BIT)) == 8'h00))
		else $error("filter enable read wrong");

	chk_unmapped_read: assert property (
		reg_rd_en_in && (reg_addr_in != TLW_ADDR_QUIET) && (reg_addr_in != TLW_ADDR_WINDOW) &&
		(reg_addr_in != TLW_ADDR_CFG) |=> reg_rd_data_out == TLW_RD_UNMAPPED)
		else $error("unmapped offset did not read zero");

	chk_idle_needs_valid: assert property (
		(state == TLW_IDLE) && !(pulse_done_in && pulse_valid_in)
		|=> !single_tap_out && (state == TLW_IDLE))
		else $error("unqualified pulse taken as tap");

	chk_quiet_holds: assert property (
		(state == TLW_QUIET) && (time_left != 8'h00) |=> state == TLW_QUIET)
		else $error("quiet time left early");

	chk_window_holds: assert property (
		(state == TLW_WINDOW) && (time_left != 8'h00) && !pulse_start_in |=> state == TLW_WINDOW)
		else $error("window closed early");

	chk_window_step_count: assert property (
		(state == TLW_WINDOW) && step_tick && (time_left != 8'h00)
		|=> time_left == $past(time_left) - 8'h01)
		else $error("window counter did not step");

	chk_ignored_only_quiet: assert property (
		(state != TLW_QUIET) |=> !pulse_ignored_out)
		else $error("pulse ignored outside quiet time");

	chk_double_needs_second: assert property (
		(state != TLW_SECOND) |=> !double_tap_out)
		else $error("double tap without a second tap");

	chk_step_lpf_base: assert property (
		tap_lowpass_enable && (sample_rate_in == 3'h0) |-> step_exp == 4'h1)
		else $error("filtered fastest step not doubled");

	chk_step_lp_cap: assert property (
		(power_mode_in == TLW_PM_LP) |-> step_exp <= (tap_lowpass_enable ? 4'h8 : 4'h6))
		else $error("low power step above cap");
endmodule

// [common/tlw_pkg.sv]
// package: register map, field layout, timing and step-schedule helpers for tap timing
package tlw_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] TLW_ADDR_CFG = 8'h0f;
	localparam logic [7:0] TLW_ADDR_QUIET = 8'h27;
	localparam logic [7:0] TLW_ADDR_WINDOW = 8'h28;
	localparam logic [7:0] TLW_RST_CFG = 8'h00;
	localparam logic [7:0] TLW_RST_QUIET = 8'h00;
	localparam logic [7:0] TLW_RST_WINDOW = 8'h00;
	localparam int TLW_LPF_BIT = 4;
	localparam logic [7:0] TLW_RD_UNMAPPED = 8'h00;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam real TLW_BASE_STEP_MS = 1.25;
	localparam real TLW_CLK_PERIOD_NS = 40.0;
	localparam int TLW_BASE_STEP_CYCLES = int'(TLW_BASE_STEP_MS * 1.0e6 / TLW_CLK_PERIOD_NS);
	localparam int TLW_MAX_COUNT = 255;
	localparam logic [3:0] TLW_MAX_EXP = 4'h8;

	// power mode encoding
	typedef enum logic [1:0] {
		TLW_PM_NORMAL = 2'b00,
		TLW_PM_LOW_POWER_LOW_NOISE_MODE = 2'b01,
		TLW_PM_HIRES = 2'b10,
		TLW_PM_LP = 2'b11
	} tlw_pm_e;

	// tap sequencing states
	typedef enum logic [1:0] {
		TLW_IDLE = 2'b00,
		TLW_QUIET = 2'b01,
		TLW_WINDOW = 2'b10,
		TLW_SECOND = 2'b11
	} tlw_state_e;

	// unfiltered doubling exponent per sample rate code (800 Hz first)
	function automatic logic [3:0] tlw_rate_exp(input logic [2:0] rate);
		case (rate)
			3'h0: tlw_rate_exp = 4'h0;
			3'h1: tlw_rate_exp = 4'h1;
			3'h2: tlw_rate_exp = 4'h2;
			3'h3: tlw_rate_exp = 4'h3;
			3'h4: tlw_rate_exp = 4'h4;
			3'h5: tlw_rate_exp = 4'h6;
			3'h6: tlw_rate_exp = 4'h7;
			default: tlw_rate_exp = 4'h9;
		endcase
	endfunction

	function automatic logic [3:0] tlw_min(input logic [3:0] a, input logic [3:0] b);
		tlw_min = (a < b) ? a : b;
	endfunction

	// step = 1.25 ms * 2^exp, same schedule for quiet time and second-tap window
	function automatic logic [3:0] tlw_step_exp(input logic [2:0] rate, input logic [1:0] pm,
		input logic lpf);
		logic [3:0] u;
		logic [3:0] d;
		u = tlw_rate_exp(rate);
		d = (u == 4'h0) ? 4'h0 : u - 4'h1;
		if (lpf) begin
			case (pm)
				TLW_PM_NORMAL: tlw_step_exp = tlw_min(u + 4'h1, 4'h5);
				TLW_PM_LOW_POWER_LOW_NOISE_MODE: tlw_step_exp = tlw_min(u + 4'h1, 4'h7);
				TLW_PM_HIRES: tlw_step_exp = tlw_min(u + 4'h1, 4'h2);
				default: tlw_step_exp = tlw_min(u + 4'h1, 4'h8);
			endcase
		end else begin
			case (pm)
				TLW_PM_NORMAL: tlw_step_exp = tlw_min(d, 4'h3);
				TLW_PM_LOW_POWER_LOW_NOISE_MODE: tlw_step_exp = tlw_min(d, 4'h5);
				TLW_PM_HIRES: tlw_step_exp = 4'h0;
				default: tlw_step_exp = tlw_min(u, 4'h6);
			endcase
		end
	endfunction

endpackage

// [design/tlw_step_tick.sv]
// step tick generator: base 1.25 ms tick scaled by a power of two
`timescale 1ns/10ps
module tlw_step_tick import tlw_pkg::*; #(
	parameter int BASE_CYCLES = TLW_BASE_STEP_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [3:0] step_exp_in,
	input wire logic restart_in,
	output logic step_tick_out
);
	localparam int CW = $clog2(BASE_CYCLES + 1);
	localparam logic [CW-1:0] BASE_LAST = CW'(BASE_CYCLES - 1);

	logic [CW-1:0] base_cnt;
	logic [7:0] pre_cnt;
	logic [8:0] span;
	logic base_done;

	assign span = 9'h001 << step_exp_in;
	assign base_done = (base_cnt == BASE_LAST);

	// ------------------------------------------------------------
	// base prescaler
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			base_cnt <= '0;
		end else if (restart_in || base_done) begin
			base_cnt <= '0;
		end else begin
			base_cnt <= base_cnt + CW'(1);
		end
	end

	// ------------------------------------------------------------
	// power-of-two step divider
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pre_cnt <= 8'h00;
			step_tick_out <= 1'b0;
		end else if (restart_in) begin
			pre_cnt <= 8'h00;
			step_tick_out <= 1'b0;
		end else if (base_done) begin
			// compare with >= so a rate change mid-step cannot run away
			if ({1'b0, pre_cnt} >= span - 9'h001) begin
				pre_cnt <= 8'h00;
				step_tick_out <= 1'b1;
			end else begin
				pre_cnt <= pre_cnt + 8'h01;
				step_tick_out <= 1'b0;
			end
		end else begin
			step_tick_out <= 1'b0;
		end
	end
endmodule

// [dv/tlw_front_model.sv]
// front-end model: emits pulse start, pulse done and width validity
`timescale 1ns/10ps
module tlw_front_model (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [7:0] width_in,
	input wire logic valid_in,
	output logic start_out = 1'b0,
	output logic done_out = 1'b0,
	output logic valid_out = 1'b0,
	output logic busy_out
);
	int cnt = 0;
	assign busy_out = (cnt != 0);
	// start, width cycles above threshold, then done; validity toggles when not qualified
	always @(negedge clk_in) begin
		start_out <= 1'b0;
		done_out <= 1'b0;
		valid_out <= ~valid_out;
		if (go_in && cnt == 0) begin
			start_out <= 1'b1;
			cnt <= width_in + 1;
		end else if (cnt == 1) begin
			done_out <= 1'b1;
			valid_out <= valid_in;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// [dv/tlw_tap_timing_tb.sv]
// self-checking bench for tap quiet-time and second-tap window timing
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tlw_tap_timing_tb;
	import tlw_pkg::*;
	localparam int BASE = 4;
	logic ref_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00;
	logic wr_en = 1'b0, rd_en = 1'b0, dbl = 1'b0;
	logic [2:0] rate = 3'h0;
	logic [1:0] pm = 2'h0;
	logic go = 1'b0, vld = 1'b0, busy, p_start, p_done, p_valid;
	logic [7:0] wid = 8'h00, rdata, r;
	logic single_tap_out, double_tap_out, pulse_ignored_out, quiet_active_out, window_active_out;
	logic rd_d1 = 1'b0, rd_d2 = 1'b0;
	logic [15:0] exp_q[$];
	int bad_count = 0, total_checks = 0, cyc = 0, n, s, e, k;
	// step exponent per {lowpass, mode}, 800 Hz in the top nibble
	logic [31:0] sched [8] = '{32'h00123333, 32'h00123555, 32'h00000000, 32'h01234666,
		32'h12345555, 32'h12345777, 32'h12222222, 32'h12345788};
	always #20 ref_clk_in = ~ref_clk_in;
	tlw_tap_timing #(.BASE_CYCLES(BASE)) dut_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
		.reg_addr_in(addr), .reg_wr_en_in(wr_en), .reg_wr_data_in(wdata), .reg_rd_en_in(rd_en),
		.reg_rd_data_out(rdata), .sample_rate_in(rate), .power_mode_in(pm),
		.double_tap_mode_in(dbl), .pulse_start_in(p_start), .pulse_done_in(p_done),
		.pulse_valid_in(p_valid), .single_tap_out(single_tap_out),
		.double_tap_out(double_tap_out), .pulse_ignored_out(pulse_ignored_out),
		.quiet_active_out(quiet_active_out), .window_active_out(window_active_out));
	tlw_front_model fe_u (.clk_in(ref_clk_in), .go_in(go), .width_in(wid), .valid_in(vld),
		.start_out(p_start), .done_out(p_done), .valid_out(p_valid), .busy_out(busy));
	// -----------------------------------------
	// drivers
	// -----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_in);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge ref_clk_in);
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_in);
		addr = a;
		rd_en = 1'b1;
		exp_q.push_back({8'h01, d});
		@(negedge ref_clk_in);
		rd_en = 1'b0;
		@(negedge ref_clk_in);
	endtask
	task automatic fire(input logic [7:0] w, input logic v);
		int g;
		@(negedge ref_clk_in);
		go <= 1'b1;
		wid <= w;
		vld <= v;
		@(negedge ref_clk_in);
		go <= 1'b0;
		g = 0;
		do begin
			@(negedge ref_clk_in);
			g++;
		end while (busy && g < 300);
	endtask
	// waits for the quiet (0) or window (1) level, then counts its length
	task automatic span(input int sel, output int n);
		int g;
		n = 0; g = 0;
		while ((sel ? window_active_out : quiet_active_out) !== 1'b1 && g < 1500) begin
			@(negedge ref_clk_in);
			g++;
		end
		while ((sel ? window_active_out : quiet_active_out) === 1'b1 && n < 1500) begin
			@(negedge ref_clk_in);
			n++;
		end
	endtask
	function automatic logic [15:0] pop();
		return exp_q.size() ? exp_q.pop_front() : 16'hffff;
	endfunction
	task automatic stop_test();
		$display("checks=%0d bad_count=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// -----------------------------------------
	// monitor: each result takes the oldest note
	// -----------------------------------------
	always @(posedge ref_clk_in) begin
		rd_d1 <= rd_en;
		rd_d2 <= rd_d1;
	end
	always @(negedge ref_clk_in) begin
		if (rd_d2) `CHK({8'h01, rdata}, pop())
		if (single_tap_out === 1'b1) `CHK(16'h0200, pop())
		if (double_tap_out === 1'b1) `CHK(16'h0300, pop())
		if (pulse_ignored_out === 1'b1) `CHK(16'h0400, pop())
	end
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			stop_test();
		end
	end
	// -----------------------------------------
	// main sequence
	// -----------------------------------------
	initial begin
		void'($urandom(32'h9a4d));
		repeat (16) @(negedge ref_clk_in);
		nrst_in = 1'b1;
		rd(TLW_ADDR_QUIET, TLW_RST_QUIET);
		rd(TLW_ADDR_WINDOW, TLW_RST_WINDOW);
		rd(TLW_ADDR_CFG, TLW_RST_CFG);
		for (k = 0; k < 4; k++) begin
			r = 8'($urandom);
			wr(TLW_ADDR_QUIET, r);
			rd(TLW_ADDR_QUIET, r);
			r = 8'($urandom);
			wr(TLW_ADDR_WINDOW, r);
			rd(TLW_ADDR_WINDOW, r);
		end
		wr(TLW_ADDR_CFG, 8'hff);
		rd(TLW_ADDR_CFG, 8'h01 << TLW_LPF_BIT);
		wr(8'h30, 8'haa);
		rd(8'h30, TLW_RD_UNMAPPED);
		// pulses of either validity inside quiet time are dropped
		wr(TLW_ADDR_CFG, 8'h00);
		wr(TLW_ADDR_QUIET, 8'd20);
		exp_q.push_back(16'h0200);
		fire(2, 1'b1);
		repeat (4) exp_q.push_back(16'h0400);
		fire(2, 1'b1);
		fire(1, 1'b0);
		span(0, n);
		// zero count still gives a quiet time of one cycle
		wr(TLW_ADDR_QUIET, 8'd0);
		exp_q.push_back(16'h0200);
		fire(2, 1'b1);
		span(0, n);
		`CHK(n >= 1 && n <= 2, 1'b1)
		// every step schedule for both timers
		wr(TLW_ADDR_QUIET, 8'd1);
		wr(TLW_ADDR_WINDOW, 8'd1);
		dbl = 1'b1;
		for (k = 0; k < 64; k++) begin
			rate = k[2:0];
			pm = k[4:3];
			wr(TLW_ADDR_CFG, 8'(k[5]) << TLW_LPF_BIT);
			e = sched[k[5:3]][4 * (7 - k[2:0]) +: 4];
			s = BASE << e;
			exp_q.push_back(16'h0200);
			fire(2, 1'b1);
			span(0, n);
			`CHK(n >= s && n <= s + 3, 1'b1)
			span(1, n);
			`CHK(n >= s && n <= s + 3, 1'b1)
		end
		// second tap: long valid, invalid, and too late
		rate = 3'h0;
		pm = 2'h0;
		wr(TLW_ADDR_CFG, 8'h00);
		wr(TLW_ADDR_QUIET, 8'd2);
		wr(TLW_ADDR_WINDOW, 8'd3);
		exp_q.push_back(16'h0200);
		fire(2, 1'b1);
		span(0, n);
		exp_q.push_back(16'h0300);
		fire(30, 1'b1);
		exp_q.push_back(16'h0200);
		fire(2, 1'b1);
		span(0, n);
		fire(3, 1'b0);
		exp_q.push_back(16'h0200);
		fire(2, 1'b1);
		span(1, n);
		`CHK(n >= 3 * BASE && n <= 3 * BASE + 3, 1'b1)
		// a pulse after the window closed is only a new first tap, never a double
		exp_q.push_back(16'h0200);
		fire(2, 1'b1);
		repeat (20) @(negedge ref_clk_in);
		`CHK(exp_q.size(), 0)
		stop_test();
	end
endmodule
